//--- core/msms_pkg.sv
package msms_pkg;

  // Register byte offsets on the Wishbone slave
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] PRESET_OFS = 8'h04;
  localparam logic [7:0] ACCEL_OFS = 8'h20;
  localparam logic [7:0] DECEL_OFS = 8'h24;
  localparam logic [7:0] SCURVE_OFS = 8'h28;
  localparam logic [7:0] STATUS_OFS = 8'h2c;
  localparam logic [7:0] SPEED_OFS = 8'h30;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h34;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h38;

  // Control register fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_SERVO_EN_BIT = 4;
  localparam int CTRL_SEL_ASSIGNED_BIT = 5;

  // Control mode parameter codes
  localparam logic [3:0] MODE_POS = 4'h0;
  localparam logic [3:0] MODE_SPD = 4'h1;
  localparam logic [3:0] MODE_TRQ = 4'h2;
  localparam logic [3:0] MODE_SPD_POS = 4'h3;
  localparam logic [3:0] MODE_TRQ_SPD = 4'h4;
  localparam logic [3:0] MODE_TRQ_POS = 4'h5;
  localparam logic [3:0] MODE_MSS_POS = 4'h6;
  localparam logic [3:0] MODE_MSS_SPD = 4'h7;
  localparam logic [3:0] MODE_MSS_TRQ = 4'h8;
  localparam logic [3:0] MODE_MSS = 4'hc;

  // Reset values
  localparam logic [3:0] CTRL_MODE_RESET = MODE_MSS;
  localparam logic [15:0] PRESET_STEP_RESET = 16'h0064;
  localparam logic [15:0] RAMP_TIME_RESET = 16'h0000;

  // Interrupt status bits
  localparam int IRQ_MODE_CHANGE_BIT = 0;
  localparam int IRQ_WARN_BIT = 1;
  localparam int IRQ_CODE_CHANGE_BIT = 2;
  localparam int IRQ_WIDTH = 3;

  // Active basic control mode, Gray coded along pos-spd-trq-mss
  typedef enum logic [1:0] {
    MSMS_POS = 2'b00,
    MSMS_SPD = 2'b01,
    MSMS_TRQ = 2'b11,
    MSMS_MSS = 2'b10
  } msms_mode_e;

  // Discrete sequence inputs from the host controller
  typedef struct packed {
    logic dir_select;
    logic mode_pair_select;
    logic speed_code_bit2;
    logic speed_code_bit1;
    logic speed_code_bit0;
    logic analog_speed_select;
    logic zero_clamp_input;
  } msms_seq_s;

  // Internal drive status used as switch-over conditions
  typedef struct packed {
    logic in_position;
    logic zero_speed;
  } msms_cond_s;

  // Command gating towards the servo loops
  typedef struct packed {
    logic pos_cmd_en;
    logic speed_cmd_en;
    logic torque_cmd_en;
    logic ramp_en;
  } msms_gate_s;

endpackage : msms_pkg

//--- core/msms_mode_select.sv
// Decided for this implementation: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ns
`default_nettype none

// What this block does
// - Direction input low forward, high reverse
// - Three select bits give eight speed codes
// - Code zero stops; codes one-seven pick presets
// - Multi-step speed uses presets and inputs only
// - Control mode code C means multi-step
// - Analog select with code zero uses analog
// - Nonzero code overrides analog select
// - Mode-pair input picks one of two modes
// - Six combined mode pairings supported
// - Combined mode without pair input warns
// - Switch only when switch-over condition holds
// - Inactive mode command inputs are ignored
// - Ramp settings apply in speed control only
// - Display flashes active mode while enabled
module msms_mode_select #(
  parameter int SPEED_W = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  // Classic Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Pins and drive-internal inputs
  input wire msms_pkg::msms_seq_s seq_pins_i,
  input wire msms_pkg::msms_cond_s cond_i,
  input wire logic signed [SPEED_W-1:0] analog_speed_i,
  // Outputs to the servo loops and display
  output logic signed [SPEED_W-1:0] speed_cmd_o,
  output msms_pkg::msms_gate_s gate_o,
  output logic [15:0] accel_time_o,
  output logic [15:0] decel_time_o,
  output logic [15:0] s_curve_time_o,
  output msms_pkg::msms_mode_e display_mode_o,
  output logic display_flash_o,
  output logic display_new_mode_o,
  output logic pin_warning_o,
  output logic irq_o
);
  import msms_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Synchroniser for the sequence pins
  msms_seq_s seq_meta_reg; // First stage, read only by second stage
  msms_seq_s seq_reg; // Clean copy used by all decoding

  // Two flops before any decode
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      seq_meta_reg <= '0;
      seq_reg <= '0;
    end else begin
      seq_meta_reg <= seq_pins_i;
      seq_reg <= seq_meta_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register file
  logic [3:0] mode_param_reg; // Control mode parameter
  logic servo_en_reg; // Servo on
  logic sel_assigned_reg; // Mode-pair input allocated
  logic [SPEED_W-1:0] preset_reg [1:7]; // Preset speeds, two's complement
  logic [15:0] accel_reg; // Acceleration time
  logic [15:0] decel_reg; // Deceleration time
  logic [15:0] scurve_reg; // S-curve time
  logic [IRQ_WIDTH-1:0] irq_stat_reg; // Sticky events
  logic [IRQ_WIDTH-1:0] irq_mask_reg; // Enables onto irq_o
  logic [IRQ_WIDTH-1:0] irq_event; // Event pulses this cycle
  logic ack_reg; // Single-cycle ack
  logic [31:0] rd_data_reg; // Read data
  logic wr_stb; // Write taken this cycle
  logic [31:0] wr_mask; // Byte enables expanded
  logic [31:0] rd_next; // Read mux

  // Access completes on the edge that raises ack
  assign wr_stb = wb_cyc_i && wb_stb_i && wb_we_i && !ack_reg;
  assign wr_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  // Merge written bytes into a register value
  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [31:0] m);
    merge = (old_v & ~m) | (new_v & m);
  endfunction : merge

  // Control register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_param_reg <= CTRL_MODE_RESET;
      servo_en_reg <= 1'b0;
      sel_assigned_reg <= 1'b0;
    end else if (wr_stb && wb_adr_i == CTRL_OFS) begin
      logic [31:0] v;
      v = merge({26'h0, sel_assigned_reg, servo_en_reg, mode_param_reg}, wb_dat_i, wr_mask);
      mode_param_reg <= v[CTRL_MODE_LSB +: 4];
      servo_en_reg <= v[CTRL_SERVO_EN_BIT];
      sel_assigned_reg <= v[CTRL_SEL_ASSIGNED_BIT];
    end
  end

  // Preset speed table, one word per code
  always_ff @(posedge clk_i) begin
    for (int i = 1; i <= 7; i++) begin
      if (rst_i) begin
        preset_reg[i] <= SPEED_W'(PRESET_STEP_RESET * i[15:0]);
      end else if (wr_stb && wb_adr_i == 8'(PRESET_OFS + 4 * (i - 1))) begin
        preset_reg[i] <= SPEED_W'(merge(32'(preset_reg[i]), wb_dat_i, wr_mask));
      end
    end
  end

  // Ramp time settings
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      accel_reg <= RAMP_TIME_RESET;
      decel_reg <= RAMP_TIME_RESET;
      scurve_reg <= RAMP_TIME_RESET;
    end else if (wr_stb) begin
      if (wb_adr_i == ACCEL_OFS) begin
        accel_reg <= 16'(merge({16'h0, accel_reg}, wb_dat_i, wr_mask));
      end
      if (wb_adr_i == DECEL_OFS) begin
        decel_reg <= 16'(merge({16'h0, decel_reg}, wb_dat_i, wr_mask));
      end
      if (wb_adr_i == SCURVE_OFS) begin
        scurve_reg <= 16'(merge({16'h0, scurve_reg}, wb_dat_i, wr_mask));
      end
    end
  end

  // Interrupt status and mask; a new event beats a write-one clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat_reg <= '0;
      irq_mask_reg <= '0;
    end else begin
      if (wr_stb && wb_adr_i == IRQ_STAT_OFS) begin
        irq_stat_reg <= (irq_stat_reg & ~(wb_dat_i[IRQ_WIDTH-1:0] & wr_mask[IRQ_WIDTH-1:0]))
                        | irq_event;
      end else begin
        irq_stat_reg <= irq_stat_reg | irq_event;
      end
      if (wr_stb && wb_adr_i == IRQ_MASK_OFS) begin
        irq_mask_reg <= IRQ_WIDTH'(merge(32'(irq_mask_reg), wb_dat_i, wr_mask));
      end
    end
  end

  assign irq_o = |(irq_stat_reg & irq_mask_reg);

  ////////////////////////////////////////////////////////////////////////////
  // Mode selection
  msms_mode_e active_reg; // Mode in force
  msms_mode_e wanted; // Mode asked for by parameter and pair input
  logic combined; // Parameter is a pairing
  logic [2:0] speed_code; // Decoded select code
  logic switch_ok; // Current mode may be left
  logic warn_reg; // Pair input missing
  logic new_mode_reg; // One-cycle change strobe
  logic [2:0] code_prev_reg; // For code-change event

  assign speed_code = {seq_reg.speed_code_bit2, seq_reg.speed_code_bit1,
                       seq_reg.speed_code_bit0};

  // Wanted mode from the parameter and the pair input
  always_comb begin
    combined = 1'b1;
    wanted = MSMS_MSS;
    unique case (mode_param_reg)
      MODE_POS: begin
        combined = 1'b0;
        wanted = MSMS_POS;
      end
      MODE_SPD: begin
        combined = 1'b0;
        wanted = MSMS_SPD;
      end
      MODE_TRQ: begin
        combined = 1'b0;
        wanted = MSMS_TRQ;
      end
      MODE_MSS: begin
        combined = 1'b0;
        wanted = MSMS_MSS;
      end
      MODE_SPD_POS: wanted = seq_reg.mode_pair_select ? MSMS_POS : MSMS_SPD;
      MODE_TRQ_SPD: wanted = seq_reg.mode_pair_select ? MSMS_SPD : MSMS_TRQ;
      MODE_TRQ_POS: wanted = seq_reg.mode_pair_select ? MSMS_POS : MSMS_TRQ;
      MODE_MSS_POS: wanted = seq_reg.mode_pair_select ? MSMS_POS : MSMS_MSS;
      MODE_MSS_SPD: wanted = seq_reg.mode_pair_select ? MSMS_SPD : MSMS_MSS;
      MODE_MSS_TRQ: wanted = seq_reg.mode_pair_select ? MSMS_TRQ : MSMS_MSS;
      default: begin
        // Unused codes fall back to plain multi-step
        combined = 1'b0;
        wanted = MSMS_MSS;
      end
    endcase
  end

  // Switch-over condition of the mode in force
  always_comb begin
    unique case (active_reg)
      MSMS_POS: switch_ok = cond_i.in_position;
      MSMS_SPD: switch_ok = cond_i.zero_speed;
      MSMS_TRQ: switch_ok = cond_i.zero_speed;
      MSMS_MSS: switch_ok = cond_i.zero_speed && speed_code == 3'h0;
    endcase
  end

  // Active mode; a plain parameter change is also held off until safe
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      active_reg <= MSMS_MSS;
      new_mode_reg <= 1'b0;
    end else begin
      new_mode_reg <= 1'b0;
      if (wanted != active_reg && switch_ok) begin
        active_reg <= wanted;
        new_mode_reg <= 1'b1;
      end
    end
  end

  // Missing pair input warning
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      warn_reg <= 1'b0;
    end else begin
      warn_reg <= combined && !sel_assigned_reg;
    end
  end

  // Previous code, for the code-change event
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      code_prev_reg <= 3'h0;
    end else begin
      code_prev_reg <= speed_code;
    end
  end

  always_comb begin
    irq_event = '0;
    irq_event[IRQ_MODE_CHANGE_BIT] = new_mode_reg;
    irq_event[IRQ_WARN_BIT] = combined && !sel_assigned_reg && !warn_reg;
    irq_event[IRQ_CODE_CHANGE_BIT] = speed_code != code_prev_reg;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Speed command
  logic signed [SPEED_W-1:0] speed_reg; // Registered command
  logic signed [SPEED_W-1:0] analog_clamped; // Analog after zero clamp
  logic signed [SPEED_W-1:0] step_speed; // Multi-step result
  logic signed [SPEED_W-1:0] speed_next; // Next command

  // Zero clamp stays usable on the analog path
  assign analog_clamped = seq_reg.zero_clamp_input ? '0 : analog_speed_i;

  always_comb begin
    if (speed_code != 3'h0) begin
      step_speed = preset_reg[speed_code];
    end else if (seq_reg.analog_speed_select) begin
      step_speed = analog_clamped;
    end else begin
      step_speed = '0;
    end
    unique case (active_reg)
      // Presets, or the clamped analog input at code zero; no offset trim
      MSMS_MSS: speed_next = seq_reg.dir_select ? -step_speed : step_speed;
      MSMS_SPD: speed_next = analog_clamped;
      // Other modes ignore the speed path
      default: speed_next = '0;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      speed_reg <= '0;
    end else begin
      speed_reg <= speed_next;
    end
  end

  assign speed_cmd_o = speed_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Command gating and ramp settings
  msms_gate_s gate_reg; // Which command inputs are live

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gate_reg <= '0;
    end else begin
      gate_reg.pos_cmd_en <= active_reg == MSMS_POS;
      gate_reg.torque_cmd_en <= active_reg == MSMS_TRQ;
      gate_reg.speed_cmd_en <= active_reg == MSMS_SPD || active_reg == MSMS_MSS;
      gate_reg.ramp_en <= active_reg == MSMS_SPD || active_reg == MSMS_MSS;
    end
  end

  assign gate_o = gate_reg;
  // Zero ramp times outside speed control, so the profiler sees no ramp
  assign accel_time_o = gate_reg.ramp_en ? accel_reg : 16'h0;
  assign decel_time_o = gate_reg.ramp_en ? decel_reg : 16'h0;
  assign s_curve_time_o = gate_reg.ramp_en ? scurve_reg : 16'h0;

  // Display follows the active mode
  assign display_mode_o = active_reg;
  assign display_flash_o = servo_en_reg;
  assign display_new_mode_o = new_mode_reg && servo_en_reg;
  assign pin_warning_o = warn_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Wishbone read path and ack
  always_comb begin
    rd_next = 32'h0;
    if (wb_adr_i >= PRESET_OFS && wb_adr_i < ACCEL_OFS && wb_adr_i[1:0] == 2'b00) begin
      rd_next = 32'(preset_reg[3'(((wb_adr_i - PRESET_OFS) >> 2) + 8'h1)]);
    end else begin
      unique case (wb_adr_i)
        CTRL_OFS: rd_next = {26'h0, sel_assigned_reg, servo_en_reg, mode_param_reg};
        ACCEL_OFS: rd_next = {16'h0, accel_reg};
        DECEL_OFS: rd_next = {16'h0, decel_reg};
        SCURVE_OFS: rd_next = {16'h0, scurve_reg};
        STATUS_OFS: rd_next = {24'h0, warn_reg, seq_reg.dir_select, speed_code, 1'b0, active_reg};
        SPEED_OFS: rd_next = 32'($unsigned(speed_reg)); // Raw word, upper half reads zero
        IRQ_STAT_OFS: rd_next = 32'(irq_stat_reg);
        IRQ_MASK_OFS: rd_next = 32'(irq_mask_reg);
        default: rd_next = 32'h0; // Unmapped reads zero
      endcase
    end
  end

  // One wait state: ack the cycle after the request appears
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      rd_data_reg <= 32'h0;
    end else begin
      ack_reg <= wb_cyc_i && wb_stb_i && !ack_reg;
      rd_data_reg <= rd_next;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rd_data_reg;

endmodule : msms_mode_select

`default_nettype wire

//--- sim/msms_mode_select_properties.sv
`timescale 1ns/1ns
`default_nettype none
module msms_chk
  import msms_pkg::*;
#(parameter int SPEED_W = 16) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire msms_seq_s seq_pins_i,
  input wire msms_cond_s cond_i,
  input wire logic signed [SPEED_W-1:0] analog_speed_i,
  input wire logic signed [SPEED_W-1:0] speed_cmd_o,
  input wire msms_gate_s gate_o,
  input wire logic [15:0] accel_time_o,
  input wire logic [15:0] decel_time_o,
  input wire logic [15:0] s_curve_time_o,
  input wire msms_mode_e display_mode_o,
  input wire logic display_flash_o,
  input wire logic display_new_mode_o,
  input wire logic pin_warning_o,
  input wire logic irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Raw speed code, as the host presents it
  logic [2:0] code;
  assign code = {seq_pins_i.speed_code_bit2, seq_pins_i.speed_code_bit1,
                 seq_pins_i.speed_code_bit0};
  wire mss = display_mode_o == MSMS_MSS;
  ////////////////////////////////////////////////////////////////////////////////
  // Four settled cycles cover both synchroniser stages and the output register
  a_ack_pulse: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus ack is not a one cycle answer");
  a_stop_code: assert property ((code == 0 && !seq_pins_i.analog_speed_select && mss)[*4]
    |=> speed_cmd_o == 0) else $error("code zero does not stop");
  a_analog_path: assert property ((code == 0 && seq_pins_i.analog_speed_select && mss
    && !seq_pins_i.zero_clamp_input && $stable(analog_speed_i))[*4]
    |=> speed_cmd_o == $past(analog_speed_i)) else $error("analog input not followed");
  a_leave_pos: assert property ($changed(display_mode_o)
    && $past(display_mode_o) == MSMS_POS |-> $past(cond_i.in_position))
    else $error("left position mode early");
  a_leave_run: assert property ($changed(display_mode_o)
    && $past(display_mode_o) != MSMS_POS |-> $past(cond_i.zero_speed))
    else $error("left moving mode early");
  a_new_mode: assert property ($changed(display_mode_o) && display_flash_o
    |-> display_new_mode_o) else $error("mode change not flagged");
  a_pulse_cause: assert property (display_new_mode_o |-> $changed(display_mode_o))
    else $error("spurious new mode pulse");
  a_pos_gate: assert property ((display_mode_o == MSMS_POS)[*3] |-> gate_o.pos_cmd_en
    && !gate_o.speed_cmd_en && !gate_o.torque_cmd_en && speed_cmd_o == 0)
    else $error("position mode gating wrong");
  a_trq_gate: assert property ((display_mode_o == MSMS_TRQ)[*3] |-> gate_o.torque_cmd_en
    && !gate_o.pos_cmd_en && speed_cmd_o == 0) else $error("torque mode gating wrong");
  a_ramp_off: assert property ((display_mode_o inside {MSMS_POS, MSMS_TRQ})[*3]
    |-> !gate_o.ramp_en && accel_time_o == 0 && decel_time_o == 0 && s_curve_time_o == 0)
    else $error("ramp times leak outside speed control");
endmodule : msms_chk
bind msms_mode_select msms_chk #(.SPEED_W(SPEED_W)) i_msms_chk (.clk_i, .rst_i, .wb_cyc_i,
  .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .seq_pins_i,
  .cond_i, .analog_speed_i, .speed_cmd_o, .gate_o, .accel_time_o, .decel_time_o,
  .s_curve_time_o, .display_mode_o, .display_flash_o, .display_new_mode_o, .pin_warning_o,
  .irq_o);
`default_nettype wire

//--- sim/msms_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module msms_host_model
  import msms_pkg::*;
(
  input wire logic clk_i,
  input wire msms_seq_s want_i,
  output var msms_seq_s seq_o
);
  // Host moves its pins only just after an edge, then holds them
  always_ff @(posedge clk_i) begin
    seq_o <= want_i;
  end
endmodule : msms_host_model
`default_nettype wire

//--- sim/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import msms_pkg::*;
  logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  logic [7:0] wb_adr_i = 0;
  logic [31:0] wb_dat_i = 0, wb_dat_o, rd;
  logic wb_ack_o, display_flash_o, display_new_mode_o, pin_warning_o, irq_o;
  msms_seq_s want = '0, seq_pins_i;
  msms_cond_s cond_i = '0;
  logic signed [15:0] analog_speed_i = 0, speed_cmd_o;
  msms_gate_s gate_o;
  logic [15:0] accel_time_o, decel_time_o, s_curve_time_o;
  msms_mode_e display_mode_o;
  int error_cnt = 0, n_checks = 0, cycles = 0;
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    forever #25 clk_i = ~clk_i;
  end
  msms_host_model i_msms_host_model (.clk_i, .want_i(want), .seq_o(seq_pins_i));
  msms_mode_select #(.SPEED_W(16)) i_msms_mode_select (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_sel_i(4'hf), .wb_dat_i, .wb_dat_o, .wb_ack_o, .seq_pins_i,
    .cond_i, .analog_speed_i, .speed_cmd_o, .gate_o, .accel_time_o, .decel_time_o,
    .s_curve_time_o, .display_mode_o, .display_flash_o, .display_new_mode_o, .pin_warning_o,
    .irq_o);
  ////////////////////////////////////////////////////////////////////////////////
  task tally_and_finish;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish
  // Hang guard, far beyond the few hundred cycles the run needs
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      error_cnt++;
      tally_and_finish();
    end
  end
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // Classic single cycle; entered and left on a rising edge
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    wb_cyc_i <= 1;
    wb_stb_i <= 1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1) @(posedge clk_i);
    rd = wb_dat_o;
    wb_cyc_i <= 0;
    wb_stb_i <= 0;
    @(posedge clk_i);
  endtask : wb
  // Pins held long enough for synchroniser and decode to settle
  task pins(input msms_seq_s s);
    want <= s;
    repeat (8) @(posedge clk_i);
  endtask : pins
  ////////////////////////////////////////////////////////////////////////////////
  task t_regs;
    wb(0, CTRL_OFS, 0);
    chk("ctrl", rd, 32'h0c);
    for (int i = 1; i < 8; i++) begin
      wb(0, PRESET_OFS + 8'(4 * (i - 1)), 0);
      chk("preset", rd, 32'(100 * i));
    end
    wb(1, 8'h3c, 32'hffff);
    wb(0, 8'h3c, 0);
    chk("unmapped", rd, 0);
  endtask : t_regs
  task t_steps;
    logic signed [15:0] e;
    wb(1, PRESET_OFS, 32'hec78);
    for (int d = 0; d < 2; d++) for (int c = 0; c < 8; c++) begin
      pins({d[0], 1'b0, 3'(c), 2'b0});
      e = (c == 1) ? -16'sd5000 : 16'(100 * c);
      if (d == 1) e = -e;
      chk("speed", speed_cmd_o, e);
    end
  endtask : t_steps
  task t_analog;
    analog_speed_i <= 16'sh1234;
    pins(7'b0000010);
    chk("analog", speed_cmd_o, 16'sh1234);
    pins(7'b0000011);
    chk("clamp", speed_cmd_o, 0);
    pins(7'b0001110);
    chk("override", speed_cmd_o, 16'sd300);
  endtask : t_analog
  task t_irq;
    wb(1, IRQ_MASK_OFS, 0);
    wb(1, IRQ_STAT_OFS, 7);
    pins(7'b0000100);
    chk("masked irq", irq_o, 0);
    wb(0, IRQ_STAT_OFS, 0);
    chk("code event", rd[2], 1);
    wb(1, IRQ_MASK_OFS, 4);
    chk("irq", irq_o, 1);
    wb(1, IRQ_STAT_OFS, 4);
    chk("irq clear", irq_o, 0);
  endtask : t_irq
  task t_pairs;
    msms_mode_e off_t[6] = '{MSMS_SPD, MSMS_TRQ, MSMS_TRQ, MSMS_MSS, MSMS_MSS, MSMS_MSS};
    msms_mode_e on_t[6] = '{MSMS_POS, MSMS_SPD, MSMS_POS, MSMS_POS, MSMS_SPD, MSMS_TRQ};
    cond_i <= 2'b11;
    wb(1, ACCEL_OFS, 32'h123);
    for (int i = 0; i < 6; i++) for (int p = 0; p < 2; p++) begin
      if (p == 0) wb(1, CTRL_OFS, 32'h30 | 32'(i + 3));
      pins({1'b0, p[0], 5'b0});
      chk("mode", display_mode_o, p ? on_t[i] : off_t[i]);
      chk("speed", speed_cmd_o, display_mode_o == MSMS_SPD ? analog_speed_i : 16'sh0);
      if (display_mode_o != MSMS_MSS) begin
        chk("accel", accel_time_o, display_mode_o == MSMS_SPD ? 16'h123 : 16'h0);
      end
    end
    wb(1, CTRL_OFS, 32'h37);
    pins(7'b0100000);
    cond_i <= 2'b10;
    pins(7'b0);
    chk("held", display_mode_o, MSMS_SPD);
    cond_i <= 2'b11;
    repeat (4) @(posedge clk_i);
    chk("released", display_mode_o, MSMS_MSS);
    pins(7'b0101000);
    chk("code held", display_mode_o, MSMS_MSS);
    wb(1, CTRL_OFS, 32'h17);
    repeat (3) @(posedge clk_i);
    chk("warning", pin_warning_o, 1);
    wb(0, IRQ_STAT_OFS, 0);
    chk("warn event", rd[1], 1);
    pins(7'b0);
    wb(1, CTRL_OFS, 32'h0c);
    chk("no warning", pin_warning_o, 0);
  endtask : t_pairs
  // Plain modes, status and speed readback, remaining ramp outputs
  task t_plain;
    pins(7'b1011000);
    chk("reverse", speed_cmd_o, -16'sd600);
    wb(0, STATUS_OFS, 0);
    chk("status", rd, 32'h72);
    wb(0, SPEED_OFS, 0);
    chk("speed word", rd, 32'h0000fda8);
    wb(1, CTRL_OFS, 32'(MODE_POS));
    repeat (4) @(posedge clk_i);
    chk("code blocks", display_mode_o, MSMS_MSS);
    pins(7'b0);
    chk("plain pos", display_mode_o, MSMS_POS);
    wb(1, CTRL_OFS, 32'(MODE_TRQ));
    repeat (4) @(posedge clk_i);
    chk("plain trq", display_mode_o, MSMS_TRQ);
    wb(1, DECEL_OFS, 32'h45);
    wb(1, SCURVE_OFS, 32'h67);
    chk("decel off", decel_time_o, 16'h0);
    chk("s curve off", s_curve_time_o, 16'h0);
    wb(1, CTRL_OFS, 32'(MODE_SPD));
    repeat (4) @(posedge clk_i);
    chk("plain spd", display_mode_o, MSMS_SPD);
    chk("decel", decel_time_o, 16'h45);
    chk("s curve", s_curve_time_o, 16'h67);
    wb(1, CTRL_OFS, 32'h0f);
    repeat (4) @(posedge clk_i);
    chk("fallback", display_mode_o, MSMS_MSS);
  endtask : t_plain
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    t_regs();
    t_steps();
    t_analog();
    t_irq();
    t_pairs();
    t_plain();
    tally_and_finish();
  end
endmodule : tb_top
`default_nettype wire
